// ---- art_pkg.sv ----
package art_pkg;
  // register indices; byte address is four times the index
  localparam logic [7:0] ART_IDX_MODE = 8'hD5;
  localparam logic [7:0] ART_IDX_FLAGS = 8'hD6;
  localparam logic [7:0] ART_IDX_CLKPS = 8'hD7;
  localparam logic [7:0] ART_IDX_RELOAD = 8'hD9;
  localparam logic [7:0] ART_IDX_COMPARE = 8'hDA;
  localparam logic [7:0] ART_IDX_LOAD = 8'hDB;
  localparam int ART_AW = 12;
  localparam logic [ART_AW-1:0] ART_ADDR_MODE = {2'b00, ART_IDX_MODE, 2'b00};
  localparam logic [ART_AW-1:0] ART_ADDR_FLAGS = {2'b00, ART_IDX_FLAGS, 2'b00};
  localparam logic [ART_AW-1:0] ART_ADDR_CLKPS = {2'b00, ART_IDX_CLKPS, 2'b00};
  localparam logic [ART_AW-1:0] ART_ADDR_RELOAD = {2'b00, ART_IDX_RELOAD, 2'b00};
  localparam logic [ART_AW-1:0] ART_ADDR_COMPARE = {2'b00, ART_IDX_COMPARE, 2'b00};
  localparam logic [ART_AW-1:0] ART_ADDR_LOAD = {2'b00, ART_IDX_LOAD, 2'b00};
  // mode control fields
  localparam int ART_MC_LOAD = 7;
  localparam int ART_MC_TEN = 6;
  localparam int ART_MC_OE = 5;
  localparam int ART_MC_EIE = 4;
  localparam int ART_MC_MATCH_IRQ_ENABLE = 3;
  localparam int ART_MC_WRAP_IRQ_ENABLE = 2;
  localparam int ART_MC_MODE_HI = 1;
  localparam int ART_MC_MODE_LO = 0;
  localparam logic [6:0] ART_MC_RESET = 7'h00;
  // flag positions
  localparam int ART_FL_EDGE = 2;
  localparam int ART_FL_MATCH = 1;
  localparam int ART_FL_WRAP = 0;
  localparam logic [2:0] ART_FL_RESET = 3'h0;
  // clock and prescale fields
  localparam int ART_CP_PS_HI = 7;
  localparam int ART_CP_PS_LO = 5;
  localparam int ART_CP_EDGE_POL = 3;
  localparam int ART_CP_EDGE_EN = 2;
  localparam int ART_CP_SRC_HI = 1;
  localparam int ART_CP_SRC_LO = 0;
  localparam logic [7:0] ART_CP_RESET = 8'h00;
  // operating modes
  localparam logic [1:0] ART_MODE_RELOAD = 2'h0;
  localparam logic [1:0] ART_MODE_CAPTURE = 2'h1;
  localparam logic [1:0] ART_MODE_CAPRST = 2'h2;
  localparam logic [1:0] ART_MODE_EXTLOAD = 2'h3;
  // clock sources
  localparam logic [1:0] ART_SRC_INT = 2'h0;
  localparam logic [1:0] ART_SRC_DIV3 = 2'h1;
  localparam logic [1:0] ART_SRC_PIN = 2'h2;
  localparam logic [1:0] ART_DIV3_LAST = 2'h2;
  localparam logic [7:0] ART_CNT_MAX = 8'hFF;
  localparam logic [7:0] ART_DATA_RESET = 8'h00;
endpackage

// ---- art_timer.sv ----
// Operation
// - load bit copies reload, clears prescaler
// - enable bit runs or freezes counting
// - output enable gates wave onto pin
// - edge request when enabled and flagged
// - match request when enabled and flagged
// - wrap request when enabled and flagged
// - two mode bits choose operating mode
// - reset clears mode control register
// - writing zero clears flag, one keeps
// - active input edge sets edge flag
// - counter equal compare sets match flag
// - rollover from max sets wrap flag
// - divider field selects power-of-two ratio
// - edge field enables and picks polarity
// - source field picks counting clock
// - load register reads/writes live counter
// - load register survives system reset
// - reload mode copies reload value on overflow
// - compare register holds match value
// - overflow sets wave, match clears it
// - capture modes copy counter on edge
// - capture-reset mode clears both counters
// - external-edge mode loads counter from reload
`timescale 1ns/10ps
module art_timer #(
  parameter int PRE_W = 7
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [art_pkg::ART_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic timer_input_pin,
  output logic timer_output_pin,
  output logic timer_irq
);
  import art_pkg::*;

  logic [6:0] mode_ctrl_reg;
  logic [2:0] flags_reg;
  logic [7:0] clkps_reg;
  logic [7:0] reload_reg;
  logic [7:0] compare_reg;
  logic [7:0] load_value_reg;
  logic [7:0] cnt_reg;
  logic [PRE_W-1:0] pre_reg;
  logic [1:0] div3_reg;
  logic pin_prev_reg;
  logic wave_reg;
  logic [31:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;
  logic out_reg;
  logic irq_reg;

  // bus decode
  wire setup_ph = psel & ~penable;
  wire commit = psel & penable & pready_reg;
  wire wr = commit & pwrite;
  wire hit_mode = (paddr == ART_ADDR_MODE);
  wire hit_flags = (paddr == ART_ADDR_FLAGS);
  wire hit_clkps = (paddr == ART_ADDR_CLKPS);
  wire hit_reload = (paddr == ART_ADDR_RELOAD);
  wire hit_compare = (paddr == ART_ADDR_COMPARE);
  wire hit_load = (paddr == ART_ADDR_LOAD);
  wire hit_any = hit_mode | hit_flags | hit_clkps | hit_reload | hit_compare | hit_load;
  wire wr_mode = wr & hit_mode;
  wire wr_flags = wr & hit_flags;
  wire wr_clkps = wr & hit_clkps;
  wire wr_reload = wr & hit_reload;
  wire wr_compare = wr & hit_compare;
  wire wr_load = wr & hit_load;
  wire [7:0] wbyte = pwdata[7:0];

  // field views
  wire count_clock_enable = mode_ctrl_reg[ART_MC_TEN];
  wire [1:0] op_mode = mode_ctrl_reg[ART_MC_MODE_HI:ART_MC_MODE_LO];
  wire [2:0] divider_select = clkps_reg[ART_CP_PS_HI:ART_CP_PS_LO];
  wire edge_en = clkps_reg[ART_CP_EDGE_EN];
  wire edge_fall = clkps_reg[ART_CP_EDGE_POL];
  wire [1:0] clk_src = clkps_reg[ART_CP_SRC_HI:ART_CP_SRC_LO];

  // input pin edges
  wire pin_rise = timer_input_pin & ~pin_prev_reg;
  wire pin_fall = ~timer_input_pin & pin_prev_reg;
  wire edge_evt = edge_en & (edge_fall ? pin_fall : pin_rise);

  wire div3_tick = (div3_reg == ART_DIV3_LAST);
  wire src_tick = (clk_src == ART_SRC_INT) ? 1'b1 :
                  (clk_src == ART_SRC_DIV3) ? div3_tick :
                  (clk_src == ART_SRC_PIN) ? pin_rise : 1'b0;
  wire pre_step = count_clock_enable & src_tick;
  // ratio is two to the divider field
  wire [PRE_W:0] pre_mask_w = ({{PRE_W{1'b0}}, 1'b1} << divider_select) - {{PRE_W{1'b0}}, 1'b1};
  wire [PRE_W-1:0] pre_mask = pre_mask_w[PRE_W-1:0];
  wire cnt_step = pre_step & ((pre_reg & pre_mask) == pre_mask);
  wire wrap_evt = cnt_step & (cnt_reg == ART_CNT_MAX);

  // load sources
  wire load_strobe = wr_mode & wbyte[ART_MC_LOAD];
  wire is_capture = (op_mode == ART_MODE_CAPTURE) | (op_mode == ART_MODE_CAPRST);
  wire capture_evt = is_capture & edge_evt;
  wire capture_clr = capture_evt & (op_mode == ART_MODE_CAPRST);
  wire ext_load = edge_evt & (op_mode == ART_MODE_EXTLOAD);

  logic [7:0] cnt_next;
  logic cnt_loaded;
  always_comb begin
    cnt_next = cnt_reg;
    cnt_loaded = 1'b1;
    if (wr_load) begin
      cnt_next = wbyte;
    end else if (load_strobe) begin
      cnt_next = reload_reg;
    end else if (ext_load) begin
      cnt_next = reload_reg;
    end else if (capture_clr) begin
      cnt_next = ART_DATA_RESET;
    end else if (wrap_evt && op_mode == ART_MODE_RELOAD) begin
      cnt_next = reload_reg;
    end else if (cnt_step) begin
      cnt_loaded = 1'b0;
      cnt_next = cnt_reg + 8'h01;
    end else begin
      cnt_loaded = 1'b0;
    end
  end
  wire cnt_moves = cnt_loaded | cnt_step;
  wire match_evt = cnt_moves & (cnt_next == compare_reg);

  wire [PRE_W-1:0] pre_next = cnt_loaded ? {PRE_W{1'b0}} :
                              pre_step ? pre_reg + {{(PRE_W-1){1'b0}}, 1'b1} : pre_reg;

  // zero clears, one keeps; set wins
  wire [2:0] flag_keep = wr_flags ? (flags_reg & wbyte[2:0]) : flags_reg;
  wire [2:0] flags_next;
  assign flags_next[ART_FL_EDGE] = flag_keep[ART_FL_EDGE] | edge_evt;
  assign flags_next[ART_FL_MATCH] = flag_keep[ART_FL_MATCH] | match_evt;
  assign flags_next[ART_FL_WRAP] = flag_keep[ART_FL_WRAP] | wrap_evt;

  wire wave_next = match_evt ? 1'b0 : (wrap_evt ? 1'b1 : wave_reg);

  wire irq_edge = mode_ctrl_reg[ART_MC_EIE] & flags_reg[ART_FL_EDGE];
  wire irq_match = mode_ctrl_reg[ART_MC_MATCH_IRQ_ENABLE] & flags_reg[ART_FL_MATCH];
  wire irq_wrap = mode_ctrl_reg[ART_MC_WRAP_IRQ_ENABLE] & flags_reg[ART_FL_WRAP];

  // read mux; load bit reads zero
  wire [7:0] rd_byte = hit_mode ? {1'b0, mode_ctrl_reg} :
                       hit_flags ? {5'h00, flags_reg} :
                       hit_clkps ? clkps_reg :
                       hit_reload ? reload_reg :
                       hit_compare ? compare_reg :
                       hit_load ? load_value_reg : 8'h00;

  // bus slave; answer prepared in setup phase
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      prdata_reg <= 32'h0000_0000;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end else begin
      pready_reg <= setup_ph;
      pslverr_reg <= setup_ph & ~hit_any;
      prdata_reg <= setup_ph ? {24'h00_0000, rd_byte} : 32'h0000_0000;
    end
  end

  // software registers
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      mode_ctrl_reg <= ART_MC_RESET;
      clkps_reg <= ART_CP_RESET;
      compare_reg <= ART_DATA_RESET;
    end else begin
      if (wr_mode) begin
        mode_ctrl_reg <= wbyte[6:0];
      end
      if (wr_clkps) begin
        clkps_reg <= wbyte;
      end
      if (wr_compare) begin
        compare_reg <= wbyte;
      end
    end
  end

  // reload and capture share one register
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      reload_reg <= ART_DATA_RESET;
    end else if (capture_evt) begin
      reload_reg <= cnt_reg;
    end else if (wr_reload) begin
      reload_reg <= wbyte;
    end
  end

  // counting chain
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cnt_reg <= ART_DATA_RESET;
      pre_reg <= {PRE_W{1'b0}};
      div3_reg <= 2'h0;
      pin_prev_reg <= 1'b0;
      flags_reg <= ART_FL_RESET;
      wave_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      pre_reg <= pre_next;
      div3_reg <= div3_tick ? 2'h0 : div3_reg + 2'h1;
      pin_prev_reg <= timer_input_pin;
      flags_reg <= flags_next;
      wave_reg <= wave_next;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst) begin
      load_value_reg <= cnt_next;
    end
  end

  // pins
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      out_reg <= 1'b0;
      irq_reg <= 1'b0;
    end else begin
      out_reg <= wave_reg & mode_ctrl_reg[ART_MC_OE];
      irq_reg <= irq_edge | irq_match | irq_wrap;
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign timer_output_pin = out_reg;
  assign timer_irq = irq_reg;
endmodule // art_timer

// ---- art_timer_asserts.sv ----
`timescale 1ns/10ps
module art_timer_asserts
  import art_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [art_pkg::ART_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic timer_input_pin,
  input wire logic timer_output_pin,
  input wire logic timer_irq
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  logic [7:0] mode_reg;
  wire mode_rd = pready && !pwrite && (paddr == ART_ADDR_MODE);
  wire mode_wr = psel && penable && pready && pwrite && !pslverr && (paddr == ART_ADDR_MODE);
  // shadow of the mode control register
  always_ff @(posedge clk_sys) begin
    if (rst) mode_reg <= 8'h00;
    else if (mode_wr) mode_reg <= pwdata[7:0];
  end
  sequence setup_s;
    psel && !penable && !pready;
  endsequence
  chk_ready_setup: assert property (setup_s |=> pready) else $error("ready late");
  chk_ready_pulse: assert property (pready |=> !pready) else $error("ready too long");
  chk_err_ready: assert property (pslverr |-> pready) else $error("error without ready");
  chk_rdata_upper: assert property (pready |-> prdata[31:8] == 24'h000000) else $error("upper data set");
  chk_load_bit_zero: assert property (mode_rd |-> !prdata[7]) else $error("load bit read");
  chk_mode_readback: assert property (mode_rd |-> prdata[6:0] == mode_reg[6:0]) else $error("mode bad");
  chk_reset_quiet: assert property (@(posedge clk_sys) disable iff (1'b0) rst |=> !timer_irq && !timer_output_pin && !pready)
    else $error("outputs active after reset");
  chk_oe_gate: assert property (!mode_reg[5] |=> !timer_output_pin) else $error("wave not gated");
  chk_irq_masked: assert property (timer_irq |-> $past(mode_reg[4:2]) != 3'h0) else $error("irq unmasked");
endmodule // art_timer_asserts
bind art_timer art_timer_asserts chk (.*);

// ---- art_pin_model.sv ----
`timescale 1ns/10ps
module art_pin_model (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic level_req,
  input wire logic timer_output_pin,
  output logic timer_input_pin,
  output logic wave_seen
);
  initial timer_input_pin = 1'b0;
  initial wave_seen = 1'b0;
  // pin changes just after the edge, synchronous to the system clock
  always @(posedge clk_sys) begin
    timer_input_pin <= level_req;
    wave_seen <= !rst && (wave_seen || timer_output_pin);
  end
endmodule // art_pin_model

// ---- tb_auto_reload_timer_regs.sv ----
`timescale 1ns/10ps
module tb_auto_reload_timer_regs;
  import art_pkg::*;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, level_req = 1'b0, err;
  logic [ART_AW-1:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata;
  logic pready, pslverr, timer_input_pin, timer_output_pin, timer_irq, wave_seen;
  logic [7:0] rd;
  int fail_count = 0, cmp_count = 0;
  always #2.5 clk_sys = ~clk_sys;
  art_timer dut (.clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .timer_input_pin(timer_input_pin), .timer_output_pin(timer_output_pin), .timer_irq(timer_irq));
  art_pin_model pins (.clk_sys(clk_sys), .rst(rst), .level_req(level_req),
    .timer_output_pin(timer_output_pin), .timer_input_pin(timer_input_pin), .wave_seen(wave_seen));
  task automatic conclude;
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic xfer(input logic w, input logic [ART_AW-1:0] a, input logic [7:0] d);
    int n;
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge clk_sys);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata[7:0];
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      fail_count++;
      $display("ERROR at %0t: no ready", $time);
      conclude();
    end
  endtask
  task automatic wr(input logic [ART_AW-1:0] a, input logic [7:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic rdchk(input logic [ART_AW-1:0] a, input logic [7:0] exp);
    xfer(1'b0, a, 8'h00);
    check(rd, exp);
  endtask
  task automatic wait_irq;
    int n;
    n = 0;
    while (timer_irq !== 1'b1 && n < 600) begin
      @(posedge clk_sys);
      n++;
    end
    check({7'h00, timer_irq}, 8'h01);
    if (timer_irq !== 1'b1) conclude();
  endtask
  initial begin
    repeat (20) @(posedge clk_sys);
    rst <= 1'b0;
    rdchk(ART_ADDR_MODE, 8'h00);
    rdchk(ART_ADDR_FLAGS, 8'h00);
    xfer(1'b0, 12'h000, 8'h00);
    check({7'h00, err}, 8'h01);
    $display("test reset done");
    wr(ART_ADDR_RELOAD, 8'hFC);
    wr(ART_ADDR_COMPARE, 8'hFE);
    wr(ART_ADDR_MODE, 8'h80);
    rdchk(ART_ADDR_LOAD, 8'hFC);
    rdchk(ART_ADDR_MODE, 8'h00);
    repeat (10) @(posedge clk_sys);
    rdchk(ART_ADDR_LOAD, 8'hFC);
    $display("test load done");
    // reserved bit kept clear by software
    wr(ART_ADDR_CLKPS, 8'h00);
    wr(ART_ADDR_MODE, 8'h64);
    wait_irq();
    wr(ART_ADDR_MODE, 8'h20);
    check({7'h00, wave_seen}, 8'h01);
    rdchk(ART_ADDR_FLAGS, 8'h03);
    wr(ART_ADDR_FLAGS, 8'h07);
    rdchk(ART_ADDR_FLAGS, 8'h03);
    wr(ART_ADDR_FLAGS, 8'h00);
    rdchk(ART_ADDR_FLAGS, 8'h00);
    $display("test count done");
    wr(ART_ADDR_CLKPS, 8'h04);
    wr(ART_ADDR_LOAD, 8'h33);
    wr(ART_ADDR_MODE, 8'h11);
    level_req <= 1'b1;
    wait_irq();
    rdchk(ART_ADDR_RELOAD, 8'h33);
    level_req <= 1'b0;
    wr(ART_ADDR_FLAGS, 8'h00);
    wr(ART_ADDR_RELOAD, 8'h55);
    wr(ART_ADDR_MODE, 8'h13);
    level_req <= 1'b1;
    repeat (6) @(posedge clk_sys);
    rdchk(ART_ADDR_LOAD, 8'h55);
    wr(ART_ADDR_CLKPS, 8'h0C);
    wr(ART_ADDR_MODE, 8'h11);
    wr(ART_ADDR_LOAD, 8'h77);
    level_req <= 1'b0;
    repeat (6) @(posedge clk_sys);
    rdchk(ART_ADDR_RELOAD, 8'h77);
    wr(ART_ADDR_LOAD, 8'h99);
    level_req <= 1'b1;
    repeat (6) @(posedge clk_sys);
    rdchk(ART_ADDR_RELOAD, 8'h77);
    wr(ART_ADDR_MODE, 8'h12);
    level_req <= 1'b0;
    repeat (6) @(posedge clk_sys);
    rdchk(ART_ADDR_LOAD, 8'h00);
    rdchk(ART_ADDR_RELOAD, 8'h99);
    $display("test edges done");
    wr(ART_ADDR_MODE, 8'h00);
    wr(ART_ADDR_CLKPS, 8'h20);
    wr(ART_ADDR_LOAD, 8'h00);
    wr(ART_ADDR_COMPARE, 8'h02);
    wr(ART_ADDR_FLAGS, 8'h00);
    // three enabled edges at ratio two give one step
    wr(ART_ADDR_MODE, 8'h48);
    wr(ART_ADDR_MODE, 8'h08);
    rdchk(ART_ADDR_LOAD, 8'h01);
    wr(ART_ADDR_MODE, 8'h48);
    wait_irq();
    rdchk(ART_ADDR_FLAGS, 8'h02);
    wr(ART_ADDR_MODE, 8'h40);
    repeat (2) @(posedge clk_sys);
    check({7'h00, timer_irq}, 8'h00);
    wr(ART_ADDR_MODE, 8'h00);
    wr(ART_ADDR_CLKPS, 8'h01);
    wr(ART_ADDR_LOAD, 8'h00);
    // three enabled edges hold exactly one divide-by-3 tick
    wr(ART_ADDR_MODE, 8'h40);
    wr(ART_ADDR_MODE, 8'h00);
    rdchk(ART_ADDR_LOAD, 8'h01);
    $display("test clocking done");
    conclude();
  end
endmodule // tb_auto_reload_timer_regs
